/* File: common/psb_cfg.svh */
// offsets, bit positions, reset values and timing figures for the sideband block
`ifndef PSB_CFG_SVH
`define PSB_CFG_SVH
`define OFF_FAST        8'h00
`define OFF_RESET       8'h04
`define OFF_CONFIG      8'h08
`define OFF_NERR_CLR    8'h0C
`define OFF_STRAP       8'h10
`define OFF_SLEEP       8'h14
`define OFF_STATUS      8'h18
`define FAST_INIT_BIT   0
`define FAST_GATE_BIT   1
`define RST_SYS_BIT     1
`define RST_FULL_BIT    2
`define CFG_SLEEP_ASSERT_ENABLE_BIT  0
`define CFG_ROUTE_BIT   11
`define CFG_BIST_BIT    12
`define CFG_NERR_EN_BIT 13
`define SLP_C2_BIT      4
`define SLP_DUAL_BIT    5
`define STRAP_RESET     4'hF
`define INIT_CLOCKS     5'h10
`define SLEEP_DELAY     4'h8
`define CLK_PERIOD_NS   20
`define STRAP_HOLD_NS   120
`define ST_S0           3'h0
`define ST_S1           3'h1
`define ST_S2           3'h2
`define ST_S3           3'h3
`define ST_S5           3'h5
`endif

/* File: common/psb_pkg.sv */
// types shared by the processor sideband block
package psb_pkg;
    typedef enum logic [3:0] {
        STRAP_HIGH  = 4'b0001,
        STRAP_DRIVE = 4'b0010,
        STRAP_HOLD  = 4'b0100,
        STRAP_DONE  = 4'b1000
    } strap_phase_e;
    typedef enum logic [3:0] {
        SLP_IDLE  = 4'b0001,
        SLP_STOP  = 4'b0010,
        SLP_WAIT  = 4'b0100,
        SLP_SLEEP = 4'b1000
    } sleep_phase_e;
    typedef struct packed {
        logic o;
        logic oe;
    } od_pin_s;
    typedef struct packed {
        logic       numeric_error_enable;
        logic       self_test_enable;
        logic       nmi_to_sci_route;
        logic       sleep_assert_enable;
    } config_s;
endpackage

/* File: rtl/processor_sideband_control.sv */
// processor sideband control: mask, soft init, numeric error, nmi routing, sleep
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "psb_cfg.svh"

// Operation
// - mask active only when both gates zero
// - soft init low 16 clocks, then released
// - soft init count freezes during stop clock
// - shutdown special cycle triggers soft init
// - fast port init bit rising triggers
// - reset port system request rising, partial
// - kbc reset low triggers; rearm on rise
// - self test plus full reset triggers init
// - numeric error only when enabled
// - error input raises internal interrupt
// - clear port drops interrupt, asserts ignore
// - ignore only while error input active
// - disabled: no interrupt, no ignore
// - serr raises nmi, or sci if routed
// - channel check raises nmi or sci
// - S1 stop clock; sleep 8 after ack
// - no C2 idle in dual processor
// - S2 sleep state not supported
// - S3-S5 pass through S1 sequence
// - processor outputs open drain
// - drive high in reset, then straps
// - strap bits map nmi,cpu_interrupt_request,ignore,mask
module processor_sideband_control (
    // apb slave
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // resets and keyboard controller
    input  wire logic             pci_reset_n,
    input  wire logic             processor_reset_n,
    input  wire logic             kbc_gate_input,
    input  wire logic             kbc_reset_request_n,
    // processor events
    input  wire logic             shutdown_cycle,
    input  wire logic             stop_grant_ack,
    input  wire logic             numeric_error_in_n,
    input  wire logic             cpu_interrupt_request_request,
    // nmi sources
    input  wire logic [2:0]       serr_active,
    input  wire logic             isa_channel_check_n,
    // processor pins
    output psb_pkg::od_pin_s      addr_bit20_mask,
    output psb_pkg::od_pin_s      soft_init,
    output psb_pkg::od_pin_s      ignore_numeric_error,
    output psb_pkg::od_pin_s      nmi_out,
    output psb_pkg::od_pin_s      cpu_interrupt_request,
    output psb_pkg::od_pin_s      stop_clock_req,
    output psb_pkg::od_pin_s      cpu_sleep_out,
    // internal events
    output logic                  numeric_error_irq,
    output logic                  sci_out
);
    localparam int STRAP_HOLD_CYC = (`STRAP_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `OFF_FAST) || (a == `OFF_RESET) || (a == `OFF_CONFIG) ||
                    (a == `OFF_NERR_CLR) || (a == `OFF_STRAP) || (a == `OFF_SLEEP) ||
                    (a == `OFF_STATUS);
    endfunction

    logic [1:0]              fast_q;
    logic [2:0]              reset_port_q;
    psb_pkg::config_s        cfg_q;
    logic [3:0]              strap_q;
    logic [5:0]              sleep_reg_q;
    logic [31:0]             prdata_q;
    logic                    pready_q;
    logic                    pslverr_q;
    logic                    wr_en;
    logic                    init_active_q;
    logic [4:0]              init_cnt_q;
    logic                    init_trig;
    logic                    kbc_armed_q;
    logic                    kbc_prev_q;
    logic                    numeric_error_in_act;
    logic                    numeric_error_in_prev_q;
    logic                    irq_q;
    logic                    ign_q;
    logic                    nmi_src_prev_q;
    logic                    nmi_q;
    logic                    sci_q;
    logic                    nmi_event;
    psb_pkg::strap_phase_e   strap_ph_q;
    logic [2:0]              strap_cnt_q;
    psb_pkg::sleep_phase_e   slp_ph_q;
    logic [3:0]              slp_cnt_q;
    logic                    stop_q;
    logic                    sleep_q;
    logic                    stop_d;
    psb_pkg::od_pin_s        mask_q;
    psb_pkg::od_pin_s        ign_pin_q;
    psb_pkg::od_pin_s        nmi_pin_q;
    psb_pkg::od_pin_s        cpu_interrupt_request_pin_q;
    logic                    init_oe_q;
    logic [4:0]              init_len_q;

    assign wr_en     = psel && penable && pready_q && pwrite && !pslverr_q;
    assign numeric_error_in_act  = !numeric_error_in_n;
    assign nmi_event = (|serr_active || !isa_channel_check_n) && !nmi_src_prev_q;

    // apb slave: no wait states, registered read data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !is_mapped(paddr);
            prdata_q  <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    `OFF_FAST:   prdata_q[1:0] <= fast_q;
                    `OFF_RESET:  prdata_q[2:0] <= reset_port_q;
                    `OFF_CONFIG:
                    begin
                        prdata_q[`CFG_NERR_EN_BIT] <= cfg_q.numeric_error_enable;
                        prdata_q[`CFG_BIST_BIT]    <= cfg_q.self_test_enable;
                        prdata_q[`CFG_ROUTE_BIT]   <= cfg_q.nmi_to_sci_route;
                        prdata_q[`CFG_SLEEP_ASSERT_ENABLE_BIT]  <= cfg_q.sleep_assert_enable;
                    end
                    `OFF_STRAP:  prdata_q[3:0] <= strap_q;
                    `OFF_SLEEP:  prdata_q[5:0] <= sleep_reg_q;
                    `OFF_STATUS: prdata_q[7:0] <= {numeric_error_in_prev_q, kbc_armed_q, sleep_q, stop_q,
                                                   irq_q, ign_q, init_active_q, mask_q.oe};
                    default:     prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fast_q       <= 2'h0;
            reset_port_q <= 3'h0;
            cfg_q        <= '0;
            strap_q      <= `STRAP_RESET;
            sleep_reg_q  <= 6'h00;
        end
        else if (wr_en)
        begin
            case (paddr)
                `OFF_FAST:   fast_q <= pwdata[1:0];
                `OFF_RESET:  reset_port_q <= pwdata[2:0];
                `OFF_CONFIG:
                begin
                    cfg_q.numeric_error_enable <= pwdata[`CFG_NERR_EN_BIT];
                    cfg_q.self_test_enable     <= pwdata[`CFG_BIST_BIT];
                    cfg_q.nmi_to_sci_route     <= pwdata[`CFG_ROUTE_BIT];
                    cfg_q.sleep_assert_enable  <= pwdata[`CFG_SLEEP_ASSERT_ENABLE_BIT];
                end
                `OFF_STRAP:  strap_q <= pwdata[3:0];
                `OFF_SLEEP:
                begin
                    sleep_reg_q[5:3] <= pwdata[5:3];
                    if (pwdata[2:0] != `ST_S2)
                        sleep_reg_q[2:0] <= pwdata[2:0];
                end
                default:     fast_q <= fast_q;
            endcase
        end
    end

    // soft init trigger sources
    always_comb
    begin
        init_trig = shutdown_cycle;
        if (wr_en && paddr == `OFF_FAST && pwdata[`FAST_INIT_BIT] && !fast_q[`FAST_INIT_BIT])
            init_trig = 1'b1;
        if (wr_en && paddr == `OFF_RESET && pwdata[`RST_SYS_BIT] && !reset_port_q[`RST_SYS_BIT])
        begin
            if (!pwdata[`RST_FULL_BIT])
                init_trig = 1'b1;
            else if (cfg_q.self_test_enable)
                init_trig = 1'b1;
        end
        if (kbc_armed_q && !kbc_reset_request_n)
            init_trig = 1'b1;
    end

    // keyboard controller reset arming
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            kbc_armed_q <= 1'b1;
            kbc_prev_q  <= 1'b1;
        end
        else
        begin
            kbc_prev_q <= kbc_reset_request_n;
            if (kbc_armed_q && !kbc_reset_request_n)
                kbc_armed_q <= 1'b0;
            else if (!kbc_prev_q && kbc_reset_request_n)
                kbc_armed_q <= 1'b1;
        end
    end

    // soft init pulse counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            init_active_q <= 1'b0;
            init_cnt_q    <= 5'h00;
            init_oe_q     <= 1'b0;
        end
        else
        begin
            init_oe_q <= init_active_q && !stop_q;
            if (!init_active_q && init_trig)
            begin
                init_active_q <= 1'b1;
                init_cnt_q    <= `INIT_CLOCKS;
            end
            else if (init_active_q && !stop_q)
            begin
                init_cnt_q <= init_cnt_q - 5'h01;
                if (init_cnt_q == 5'h01)
                    init_active_q <= 1'b0;
            end
        end
    end

    // numeric error handshake
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            numeric_error_in_prev_q <= 1'b0;
            irq_q       <= 1'b0;
            ign_q       <= 1'b0;
        end
        else
        begin
            numeric_error_in_prev_q <= numeric_error_in_act;
            if (!cfg_q.numeric_error_enable)
            begin
                irq_q <= 1'b0;
                ign_q <= 1'b0;
            end
            else
            begin
                if (numeric_error_in_act && !numeric_error_in_prev_q)
                    irq_q <= 1'b1;
                else if (wr_en && paddr == `OFF_NERR_CLR)
                    irq_q <= 1'b0;
                if (!numeric_error_in_act)
                    ign_q <= 1'b0;
                else if (wr_en && paddr == `OFF_NERR_CLR)
                    ign_q <= 1'b1;
            end
        end
    end

    // nmi and sci routing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmi_src_prev_q <= 1'b0;
            nmi_q          <= 1'b0;
            sci_q          <= 1'b0;
        end
        else
        begin
            nmi_src_prev_q <= |serr_active || !isa_channel_check_n;
            nmi_q          <= nmi_event && !cfg_q.nmi_to_sci_route;
            sci_q          <= nmi_event && cfg_q.nmi_to_sci_route;
        end
    end

    // sleep entry sequence
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slp_ph_q  <= psb_pkg::SLP_IDLE;
            slp_cnt_q <= 4'h0;
        end
        else
        begin
            case (slp_ph_q)
                psb_pkg::SLP_IDLE:
                    if (sleep_reg_q[2:0] != `ST_S0 && sleep_reg_q[2:0] <= `ST_S5)
                        slp_ph_q <= psb_pkg::SLP_STOP;
                psb_pkg::SLP_STOP:
                    if (sleep_reg_q[2:0] == `ST_S0)
                        slp_ph_q <= psb_pkg::SLP_IDLE;
                    else if (stop_grant_ack && cfg_q.sleep_assert_enable)
                    begin
                        slp_ph_q  <= psb_pkg::SLP_WAIT;
                        slp_cnt_q <= `SLEEP_DELAY - 4'h2;
                    end
                psb_pkg::SLP_WAIT:
                    if (sleep_reg_q[2:0] == `ST_S0)
                        slp_ph_q <= psb_pkg::SLP_IDLE;
                    else if (slp_cnt_q == 4'h0)
                        slp_ph_q <= psb_pkg::SLP_SLEEP;
                    else
                        slp_cnt_q <= slp_cnt_q - 4'h1;
                psb_pkg::SLP_SLEEP:
                    if (sleep_reg_q[2:0] == `ST_S0)
                        slp_ph_q <= psb_pkg::SLP_IDLE;
                default:
                    slp_ph_q <= psb_pkg::SLP_IDLE;
            endcase
        end
    end

    // stop clock also serves C2, only for single processor
    assign stop_d = (slp_ph_q != psb_pkg::SLP_IDLE) ||
                    (sleep_reg_q[`SLP_C2_BIT] && !sleep_reg_q[`SLP_DUAL_BIT]);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stop_q  <= 1'b0;
            sleep_q <= 1'b0;
        end
        else
        begin
            stop_q  <= stop_d;
            sleep_q <= slp_ph_q == psb_pkg::SLP_SLEEP;
        end
    end

    // strap phase around processor reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_ph_q  <= psb_pkg::STRAP_HIGH;
            strap_cnt_q <= 3'h0;
        end
        else if (!pci_reset_n)
            strap_ph_q <= psb_pkg::STRAP_HIGH;
        else
        begin
            case (strap_ph_q)
                psb_pkg::STRAP_HIGH:  strap_ph_q <= psb_pkg::STRAP_DRIVE;
                psb_pkg::STRAP_DRIVE:
                    if (processor_reset_n)
                    begin
                        strap_ph_q  <= psb_pkg::STRAP_HOLD;
                        strap_cnt_q <= 3'(STRAP_HOLD_CYC - 1);
                    end
                psb_pkg::STRAP_HOLD:
                    if (strap_cnt_q == 3'h0)
                        strap_ph_q <= psb_pkg::STRAP_DONE;
                    else
                        strap_cnt_q <= strap_cnt_q - 3'h1;
                psb_pkg::STRAP_DONE:  strap_ph_q <= psb_pkg::STRAP_DONE;
                default:              strap_ph_q <= psb_pkg::STRAP_HIGH;
            endcase
        end
    end

    // processor pin drivers: low or released, straps drive both levels
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_q     <= '{o: 1'b1, oe: 1'b1};
            ign_pin_q  <= '{o: 1'b1, oe: 1'b1};
            nmi_pin_q  <= '{o: 1'b1, oe: 1'b1};
            cpu_interrupt_request_pin_q <= '{o: 1'b1, oe: 1'b1};
        end
        else if (!pci_reset_n || strap_ph_q == psb_pkg::STRAP_HIGH)
        begin
            mask_q     <= '{o: 1'b1, oe: 1'b1};
            ign_pin_q  <= '{o: 1'b1, oe: 1'b1};
            nmi_pin_q  <= '{o: 1'b1, oe: 1'b1};
            cpu_interrupt_request_pin_q <= '{o: 1'b1, oe: 1'b1};
        end
        else if (strap_ph_q != psb_pkg::STRAP_DONE)
        begin
            nmi_pin_q  <= '{o: strap_q[3], oe: 1'b1};
            cpu_interrupt_request_pin_q <= '{o: strap_q[2], oe: 1'b1};
            ign_pin_q  <= '{o: strap_q[1], oe: 1'b1};
            mask_q     <= '{o: strap_q[0], oe: 1'b1};
        end
        else
        begin
            mask_q     <= '{o: 1'b0, oe: !fast_q[`FAST_GATE_BIT] && !kbc_gate_input};
            ign_pin_q  <= '{o: 1'b0, oe: ign_q && numeric_error_in_act};
            nmi_pin_q  <= '{o: 1'b0, oe: !nmi_q};
            cpu_interrupt_request_pin_q <= '{o: 1'b0, oe: !cpu_interrupt_request_request};
        end
    end

    assign prdata                = prdata_q;
    assign pready                = pready_q;
    assign pslverr               = pslverr_q;
    assign addr_bit20_mask       = mask_q;
    assign ignore_numeric_error  = ign_pin_q;
    assign nmi_out               = nmi_pin_q;
    assign cpu_interrupt_request = cpu_interrupt_request_pin_q;
    assign soft_init             = '{o: 1'b0, oe: init_oe_q};
    assign stop_clock_req        = '{o: 1'b0, oe: stop_q};
    assign cpu_sleep_out         = '{o: 1'b0, oe: sleep_q};
    assign numeric_error_irq     = irq_q;
    assign sci_out               = sci_q;

    // length of soft init drive, frozen cycles excluded
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            init_len_q <= 5'h00;
        else if (init_oe_q)
            init_len_q <= init_len_q + 5'h01;
        else if (!init_active_q)
            init_len_q <= 5'h00;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ack_taken;
        slp_ph_q == psb_pkg::SLP_STOP && stop_grant_ack && cfg_q.sleep_assert_enable &&
            sleep_reg_q[2:0] != `ST_S0;
    endsequence
    sequence s_stay_asleep;
        (sleep_reg_q[2:0] != `ST_S0)[*8];
    endsequence

    property p_mask;
        strap_ph_q == psb_pkg::STRAP_DONE && pci_reset_n |=>
            mask_q.oe == $past(!fast_q[`FAST_GATE_BIT] && !kbc_gate_input);
    endproperty
    a_mask: assert property (p_mask) else $error("mask pin disagrees with gates");

    property p_init_len;
        $fell(init_oe_q) && !init_active_q |-> init_len_q == `INIT_CLOCKS;
    endproperty
    a_init_len: assert property (p_init_len) else $error("soft init length wrong");

    property p_init_freeze;
        init_active_q && stop_q |=> $stable(init_cnt_q) && init_active_q;
    endproperty
    a_init_freeze: assert property (p_init_freeze) else $error("soft init ran in stop");

    property p_no_restart;
        init_active_q && init_trig && !stop_q |=> init_cnt_q == $past(init_cnt_q) - 5'h01;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("soft init restarted");

    property p_irq_set;
        cfg_q.numeric_error_enable && numeric_error_in_act && !numeric_error_in_prev_q |=> irq_q ##1 numeric_error_irq;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("numeric irq missing");

    property p_disabled;
        !cfg_q.numeric_error_enable |=> !irq_q && !ign_q;
    endproperty
    a_disabled: assert property (p_disabled) else $error("numeric path active");

    property p_ign_needs_err;
        ign_pin_q.oe && $past(strap_ph_q == psb_pkg::STRAP_DONE && pci_reset_n) |->
            $past(numeric_error_in_act);
    endproperty
    a_ign_needs_err: assert property (p_ign_needs_err) else $error("ignore without error");

    property p_route;
        nmi_event |=> (sci_q == $past(cfg_q.nmi_to_sci_route)) && (nmi_q != sci_q);
    endproperty
    a_route: assert property (p_route) else $error("nmi routing wrong");

    property p_sleep_delay;
        s_ack_taken ##1 s_stay_asleep |=> cpu_sleep_out.oe && stop_clock_req.oe;
    endproperty
    a_sleep_delay: assert property (p_sleep_delay) else $error("sleep not after 8");

    property p_reset_high;
        !pci_reset_n |=> mask_q.o && mask_q.oe && nmi_pin_q.o && cpu_interrupt_request_pin_q.o && ign_pin_q.o;
    endproperty
    a_reset_high: assert property (p_reset_high) else $error("pins low in pci reset");
endmodule

/* File: sim/cpu_model.sv */
// processor model that answers stop clock with a stop grant acknowledge
`timescale 1ns/1ps
module cpu_model #(
    parameter int ACK_DELAY = 2
) (
    // clock
    input  wire logic             pclk,
    // processor pins
    input  wire psb_pkg::od_pin_s stop_clock_req,
    output logic                  stop_grant_ack
);
    int cnt_q = 0;
    initial stop_grant_ack = 1'b0;
    // one acknowledge per stop clock assertion, after a settable delay
    always @(posedge pclk)
    begin
        stop_grant_ack <= 1'b0;
        if (stop_clock_req.oe !== 1'b1)
            cnt_q <= 0;
        else if (cnt_q <= ACK_DELAY)
            cnt_q <= cnt_q + 1;
        if (stop_clock_req.oe === 1'b1 && cnt_q == ACK_DELAY)
            stop_grant_ack <= 1'b1;
    end
endmodule

/* File: sim/processor_sideband_control_tb.sv */
// self-checking bench for the processor sideband block
`timescale 1ns/1ps
module processor_sideband_control_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, numeric_error_irq, sci_out, stop_grant_ack;
    logic pci_reset_n = 0, processor_reset_n = 0, kbc_gate_input = 0, kbc_reset_request_n = 1;
    logic shutdown_cycle = 0, numeric_error_in_n = 1, cpu_interrupt_request_request = 0, isa_channel_check_n = 1;
    logic [2:0] serr_active = 3'h0;
    psb_pkg::od_pin_s addr_bit20_mask, soft_init, ignore_numeric_error, nmi_out;
    psb_pkg::od_pin_s cpu_interrupt_request, stop_clock_req, cpu_sleep_out;
    logic [31:0] exp_q[$], got_q[$];
    event got_ev;
    int miscompares = 0, samples_checked = 0, n, k, r;
    always #10 pclk = ~pclk;
    processor_sideband_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pci_reset_n, .processor_reset_n, .kbc_gate_input,
        .kbc_reset_request_n, .shutdown_cycle, .stop_grant_ack, .numeric_error_in_n,
        .cpu_interrupt_request_request, .serr_active, .isa_channel_check_n, .addr_bit20_mask, .soft_init,
        .ignore_numeric_error, .nmi_out, .cpu_interrupt_request, .stop_clock_req,
        .cpu_sleep_out, .numeric_error_irq, .sci_out);
    cpu_model u_cpu (.pclk, .stop_clock_req, .stop_grant_ack);
    task automatic note(input logic [31:0] g, input logic [31:0] e);
        got_q.push_back(g);
        exp_q.push_back(e);
        ->got_ev;
    endtask
    // compares the oldest expectation with each observed result
    always @(got_ev)
    begin
        while (got_q.size() > 0)
        begin
            samples_checked++;
            if (got_q[0] !== exp_q[0])
            begin
                miscompares++;
                $display("mismatch at %0t: got %h expected %h", $time, got_q[0], exp_q[0]);
            end
            void'(got_q.pop_front());
            void'(exp_q.pop_front());
        end
    end
    task automatic report_and_stop();
        #1;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic hang();
        miscompares++;
        report_and_stop();
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do
        begin
            @(posedge pclk);
            t++;
        end
        while (pready !== 1'b1 && t < 50);
        if (t == 50) hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // counts soft init drive cycles, retriggering in mid-pulse
    task automatic pulse_len(output int c);
        int t;
        c = 0;
        for (t = 0; t < 60; t++)
        begin
            @(posedge pclk);
            shutdown_cycle <= (t == 6);
            if (soft_init.oe === 1'b1) c++;
        end
    endtask
    initial
    begin
        void'($urandom(32'h5EC8));
        cyc(6);
        presetn <= 1'b1;
        cyc(3);
        note({nmi_out.o, nmi_out.oe}, 2'h3);
        pci_reset_n <= 1'b1;
        processor_reset_n <= 1'b1;
        cyc(12);
        apb(1'b0, 8'h1C, 32'h0);
        note({err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, 8'h00, 32'h0);
        cyc(3);
        note({addr_bit20_mask.o, addr_bit20_mask.oe}, 2'h1);
        kbc_gate_input <= 1'b1;
        cyc(3);
        note(addr_bit20_mask.oe, 1'b0);
        for (k = 0; k < 5; k++)
        begin
            if (k == 0) shutdown_cycle <= 1'b1;
            if (k == 1) apb(1'b1, 8'h00, 32'h3);
            if (k == 2) kbc_reset_request_n <= 1'b0;
            if (k == 3) apb(1'b1, 8'h04, 32'h2);
            if (k == 4)
            begin
                apb(1'b1, 8'h08, 32'h1000);
                apb(1'b1, 8'h04, 32'h0);
                apb(1'b1, 8'h04, 32'h6);
            end
            pulse_len(n);
            note(n, 16);
        end
        kbc_reset_request_n <= 1'b1;
        apb(1'b1, 8'h08, 32'h2000);
        numeric_error_in_n <= 1'b0;
        cyc(3);
        note({numeric_error_irq, ignore_numeric_error.oe}, 2'h2);
        apb(1'b1, 8'h0C, $urandom);
        cyc(3);
        note({numeric_error_irq, ignore_numeric_error.oe}, 2'h1);
        numeric_error_in_n <= 1'b1;
        cyc(3);
        note(ignore_numeric_error.oe, 1'b0);
        apb(1'b1, 8'h08, 32'h0);
        numeric_error_in_n <= 1'b0;
        cyc(3);
        apb(1'b1, 8'h0C, $urandom);
        cyc(3);
        note({numeric_error_irq, ignore_numeric_error.oe}, 2'h0);
        numeric_error_in_n <= 1'b1;
        cpu_interrupt_request_request <= 1'b1;
        cyc(2);
        note({cpu_interrupt_request.o, cpu_interrupt_request.oe}, 2'h0);
        cpu_interrupt_request_request <= 1'b0;
        cyc(2);
        note({cpu_interrupt_request.o, cpu_interrupt_request.oe}, 2'h1);
        for (k = 0; k < 8; k++)
        begin
            apb(1'b1, 8'h08, {20'h0, k[0], 11'h0});
            if (k[2:1] == 2'h3) isa_channel_check_n <= 1'b0;
            else serr_active[k[2:1]] <= 1'b1;
            n = 0;
            r = 0;
            repeat (6)
            begin
                @(posedge pclk);
                n += (nmi_out.oe === 1'b0);
                r += (sci_out === 1'b1);
            end
            note({n[3:0], r[3:0]}, k[0] ? 8'h01 : 8'h10);
            serr_active <= 3'h0;
            isa_channel_check_n <= 1'b1;
        end
        apb(1'b1, 8'h14, 32'h2);
        cyc(4);
        note(stop_clock_req.oe, 1'b0);
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b1, 8'h14, 32'h1);
        for (n = 0; stop_grant_ack !== 1'b1 && n < 50; n++) @(posedge pclk);
        if (n == 50) hang();
        note({stop_clock_req.o, stop_clock_req.oe}, 2'h1);
        for (n = 0; cpu_sleep_out.oe !== 1'b1 && n < 50; n++) @(posedge pclk);
        if (n == 50) hang();
        note(n, 9);
        shutdown_cycle <= 1'b1;
        cyc(1);
        shutdown_cycle <= 1'b0;
        cyc(5);
        note(soft_init.oe, 1'b0);
        apb(1'b1, 8'h14, 32'h0);
        pulse_len(n);
        note(n, 16);
        r = $urandom;
        apb(1'b1, 8'h10, r);
        pci_reset_n <= 1'b0;
        processor_reset_n <= 1'b0;
        cyc(3);
        note({nmi_out.o, addr_bit20_mask.o}, 2'h3);
        pci_reset_n <= 1'b1;
        cyc(4);
        note({nmi_out.o, cpu_interrupt_request.o, ignore_numeric_error.o, addr_bit20_mask.o},
            r[3:0]);
        processor_reset_n <= 1'b1;
        cyc(12);
        report_and_stop();
    end
endmodule
